// ==== hdl/boot_map_dev.sv ====
// Boot map decoder: memory map, vector mirror and readout lock.
// Assumes the far end holds the configuration words stable around reset.
//
// Local design decision: the address-and-strobe port.
`include "boot_map_defs.svh"
module boot_map_dev #(
  parameter logic [31:0] APP_SIZE = `BM_APP_SIZE
) (
  input  wire logic   ref_clk,
  input  wire logic   sys_rst,
  boot_map_if.dev     lnk,
  output logic        boot_from_loader,
  output logic        iap_active,
  output logic        lock_active,
  output logic        df_enable,
  output logic [31:0] df_base,
  output logic        cfg_fault,
  output logic        cfg_loaded
);
  // -----------------------------------------------------------
  // Configuration capture
  // -----------------------------------------------------------
  logic [31:0] boot_r;
  logic [31:0] flash_r;
  logic        loaded_r;
  logic [31:0] vec_page_r;
  logic [31:0] vec_page_nxt;
  logic        vec_we;
  // Captured once; later changes of the words wait for the next reset.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      boot_r   <= `BM_BOOT_ERASED;
      flash_r  <= 32'h0000_0000;
      loaded_r <= 1'b0;
    end else if (!loaded_r) begin
      boot_r   <= lnk.boot_word;
      flash_r  <= lnk.flash_word;
      loaded_r <= 1'b1;
    end
  end

  // -----------------------------------------------------------
  // Decoded settings
  // -----------------------------------------------------------
  wire [1:0]  boot_select      = boot_r[`BM_CBS_HI:`BM_CBS_LO];
  wire        in_application_program      = loaded_r & ~boot_select[0];
  wire        from_ldr = ~boot_select[1];
  wire        locked   = ~boot_r[`BM_LOCK_BIT];
  wire        df_on    = loaded_r & (APP_SIZE == `BM_DF_APP_SIZE) & ~boot_r[`BM_DATA_FLASH_ENABLE_BIT];
  wire [31:0] df_addr  = {12'h000, flash_r[`BM_DFBASE_HI:`BM_PAGE_BITS], 9'h000};
  wire        df_bad   = (flash_r[31:`BM_RSV_LO] != 12'h000) | (flash_r[`BM_PAGE_BITS-1:0] != 9'h000);

  // -----------------------------------------------------------
  // Core access decode
  // -----------------------------------------------------------
  wire [31:0] ca        = lnk.core_addr;
  wire        ca_vec    = ca[31:`BM_PAGE_BITS] == 23'h000000;
  wire        ca_app    = ca < APP_SIZE;
  wire        ca_ldrwin = ca[31:`BM_LDR_BITS] == `BM_LDR_BASE >> `BM_LDR_BITS;
  wire        ca_ldrlow = ca[31:`BM_LDR_BITS] == 20'h00000;
  wire        vec_ldr   = vec_page_r[31:`BM_LDR_BITS] == `BM_LDR_BASE >> `BM_LDR_BITS;
  wire [31:0] ldr_phys  = `BM_LDR_BASE | {20'h00000, ca[`BM_LDR_BITS-1:0]};
  wire [31:0] vec_phys  = vec_page_r | {23'h000000, ca[`BM_PAGE_BITS-1:0]};
  boot_map_pkg::region_t map_rgn;
  logic [31:0]           map_phys;

  always_comb begin
    map_rgn  = boot_map_pkg::rgn_none;
    map_phys = 32'h0000_0000;
    if (loaded_r) begin
      case (boot_select)
        2'b11: begin
          if (ca_app) begin
            map_rgn  = boot_map_pkg::rgn_app;
            map_phys = ca;
          end
        end
        2'b01: begin
          if (ca_ldrlow) begin
            map_rgn  = boot_map_pkg::rgn_ldr;
            map_phys = ldr_phys;
          end
        end
        2'b10, 2'b00: begin
          if (ca_vec) begin
            map_rgn  = vec_ldr ? boot_map_pkg::rgn_ldr : boot_map_pkg::rgn_app;
            map_phys = vec_phys;
          end else if (ca_app) begin
            map_rgn  = boot_map_pkg::rgn_app;
            map_phys = ca;
          end else if (ca_ldrwin) begin
            map_rgn  = boot_map_pkg::rgn_ldr;
            map_phys = ca;
          end
        end
        default: begin
          map_rgn  = boot_map_pkg::rgn_none;
          map_phys = 32'h0000_0000;
        end
      endcase
      if (map_rgn == boot_map_pkg::rgn_app && df_on && map_phys >= df_addr) begin
        map_rgn = boot_map_pkg::rgn_dfl;
      end
    end
  end

  // -----------------------------------------------------------
  // Debug read filter
  // -----------------------------------------------------------
  wire dbg_open = !locked | (lnk.dbg_addr == `BM_ID_ADDR) | (lnk.dbg_addr == `BM_CFG0_ADDR) |
                  (lnk.dbg_addr == `BM_CFG1_ADDR);
  wire [31:0] dbg_word = dbg_open ? lnk.raw_data : `BM_ALL_ONES;

  // -----------------------------------------------------------
  // Program command decode
  // -----------------------------------------------------------
  wire [31:0] ta        = lnk.isp_addr;
  wire        ta_align  = ta[`BM_PAGE_BITS-1:0] == 9'h000;
  wire        ta_page0  = ta[31:`BM_PAGE_BITS] == 23'h000000;
  wire        ta_app    = (ta < APP_SIZE) & !(boot_select == 2'b00 & ta_page0);
  wire        ta_ldr    = ta[31:`BM_LDR_BITS] == `BM_LDR_BASE >> `BM_LDR_BITS;
  wire        remap_ok  = in_application_program & ta_align & (ta_app | ta_ldr);
  wire        is_read   = (lnk.isp_cmd == `BM_CMD_READ) | (lnk.isp_cmd == `BM_CMD_READ_ID);
  wire        is_erase  = lnk.isp_cmd == `BM_CMD_ERASE;
  wire        is_prog   = lnk.isp_cmd == `BM_CMD_PROGRAM;
  wire        is_remap  = lnk.isp_cmd == `BM_CMD_REMAP;
  wire        cfg_hit   = is_erase & ta_align & (ta == `BM_CFG0_ADDR);
  wire        cmd_ok    = is_read | is_prog | (is_erase & ta_align) | (is_remap & remap_ok);
  wire        go        = lnk.isp_go & loaded_r;

  // Loader boot with IN_APPLICATION_PROGRAM starts with the loader's first page mirrored.
  assign vec_we       = (!loaded_r) | (go & is_remap & remap_ok);
  assign vec_page_nxt = !loaded_r ? ((lnk.boot_word[`BM_CBS_HI:`BM_CBS_LO] == 2'b00) ? `BM_LDR_BASE
                                     : 32'h0000_0000)
                                  : ta;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      vec_page_r <= 32'h0000_0000;
    end else if (vec_we) begin
      vec_page_r <= vec_page_nxt;
    end
  end

  // -----------------------------------------------------------
  // Registered answers
  // -----------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lnk.core_ack    <= 1'b0;
      lnk.core_region <= boot_map_pkg::rgn_none;
      lnk.core_phys   <= 32'h0000_0000;
      lnk.dbg_ack     <= 1'b0;
      lnk.dbg_rdata   <= 32'h0000_0000;
    end else begin
      lnk.core_ack    <= lnk.core_req;
      lnk.dbg_ack     <= lnk.dbg_req;
      if (lnk.core_req) begin
        lnk.core_region <= map_rgn;
        lnk.core_phys   <= map_phys;
      end
      if (lnk.dbg_req) begin
        lnk.dbg_rdata <= dbg_word;
      end
    end
  end

  // A refused command leaves every map setting untouched and only raises fail.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lnk.isp_done  <= 1'b0;
      lnk.isp_fail  <= 1'b0;
      lnk.isp_rdata <= 32'h0000_0000;
      lnk.cfg_erase <= 1'b0;
    end else begin
      lnk.isp_done  <= go;
      lnk.cfg_erase <= (go & cfg_hit) | lnk.chip_erase;
      if (go) begin
        lnk.isp_fail <= !cmd_ok;
        if (is_read) begin
          lnk.isp_rdata <= lnk.raw_data;
        end
      end
    end
  end

  // -----------------------------------------------------------
  // User-side status
  // -----------------------------------------------------------
  assign lnk.vec_page = vec_page_r;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      boot_from_loader <= 1'b0;
      iap_active       <= 1'b0;
      lock_active      <= 1'b0;
      df_enable        <= 1'b0;
      df_base          <= 32'h0000_0000;
      cfg_fault        <= 1'b0;
      cfg_loaded       <= 1'b0;
    end else begin
      boot_from_loader <= loaded_r & from_ldr;
      iap_active       <= in_application_program;
      lock_active      <= loaded_r & locked;
      df_enable        <= df_on;
      df_base          <= df_addr;
      cfg_fault        <= loaded_r & df_bad;
      cfg_loaded       <= loaded_r;
    end
  end
endmodule // boot_map_dev

// ==== hdl/boot_map_defs.svh ====
// Constants shared by the boot map decoder and its controller end.
// Assumes inclusion by bare name from any file that needs it.
`ifndef BOOT_MAP_DEFS_SVH
`define BOOT_MAP_DEFS_SVH
// -----------------------------------------------------------
// Configuration word fields
// -----------------------------------------------------------
`define BM_CBS_HI        7
`define BM_CBS_LO        6
`define BM_LOCK_BIT      1
`define BM_DATA_FLASH_ENABLE_BIT      0
`define BM_DFBASE_HI     19
`define BM_RSV_LO        20
`define BM_PAGE_BITS     9
`define BM_BOOT_ERASED   32'hffff_ffff
`define BM_FLASH_ERASED  32'h000f_fe00
`define BM_FLASH_MASK    32'h000f_fe00
// -----------------------------------------------------------
// Address map
// -----------------------------------------------------------
`define BM_LDR_BASE      32'h0010_0000
`define BM_LDR_BITS      12
`define BM_APP_SIZE      32'h0002_0000
`define BM_DF_APP_SIZE   32'h0002_0000
`define BM_CFG0_ADDR     32'h0030_0000
`define BM_CFG1_ADDR     32'h0030_0004
`define BM_ID_ADDR       32'h0040_0000
`define BM_ALL_ONES      32'hffff_ffff
// -----------------------------------------------------------
// Program commands
// -----------------------------------------------------------
`define BM_CMD_READ      8'h00
`define BM_CMD_READ_ID   8'h04
`define BM_CMD_PROGRAM   8'h21
`define BM_CMD_ERASE     8'h22
`define BM_CMD_REMAP     8'h2e
// -----------------------------------------------------------
// Controller register offsets and trigger bits
// -----------------------------------------------------------
`define BM_REG_BOOT      8'h00
`define BM_REG_FLASH     8'h04
`define BM_REG_CMD       8'h08
`define BM_REG_TARGET    8'h0c
`define BM_REG_DATA      8'h10
`define BM_REG_ACCESS    8'h14
`define BM_REG_TRIGGER   8'h18
`define BM_REG_STATUS    8'h1c
`define BM_REG_RESULT    8'h20
`define BM_REG_PHYS      8'h24
`define BM_TRG_GO        0
`define BM_TRG_CHIP      1
`define BM_TRG_DBG       2
`define BM_TRG_CORE      3
`endif

// ==== hdl/boot_map_pkg.sv ====
// Types shared by both ends of the boot map link.
// Assumes nothing beyond a SystemVerilog compiler.
package boot_map_pkg;
  typedef enum logic [1:0] {
    rgn_none = 2'b00,
    rgn_app  = 2'b01,
    rgn_ldr  = 2'b11,
    rgn_dfl  = 2'b10
  } region_t;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_busy = 2'b01,
    st_done = 2'b11
  } isp_state_t;
endpackage

// ==== hdl/boot_map_if.sv ====
// Link between the boot map decoder and the controller that feeds it.
// Assumes both ends run on the same clock.
interface boot_map_if;
  logic [31:0]          boot_word;
  logic [31:0]          flash_word;
  logic                 core_req;
  logic [31:0]          core_addr;
  logic                 core_ack;
  boot_map_pkg::region_t core_region;
  logic [31:0]          core_phys;
  logic                 dbg_req;
  logic [31:0]          dbg_addr;
  logic [31:0]          dbg_rdata;
  logic                 dbg_ack;
  logic [31:0]          raw_data;
  logic                 isp_go;
  logic [7:0]           isp_cmd;
  logic [31:0]          isp_addr;
  logic                 isp_done;
  logic                 isp_fail;
  logic [31:0]          isp_rdata;
  logic [31:0]          vec_page;
  logic                 chip_erase;
  logic                 cfg_erase;
  modport dev (
    input  boot_word, flash_word, core_req, core_addr, dbg_req, dbg_addr, raw_data,
    input  isp_go, isp_cmd, isp_addr, chip_erase,
    output core_ack, core_region, core_phys, dbg_rdata, dbg_ack,
    output isp_done, isp_fail, isp_rdata, vec_page, cfg_erase
  );
  modport host (
    output boot_word, flash_word, core_req, core_addr, dbg_req, dbg_addr, raw_data,
    output isp_go, isp_cmd, isp_addr, chip_erase,
    input  core_ack, core_region, core_phys, dbg_rdata, dbg_ack,
    input  isp_done, isp_fail, isp_rdata, vec_page, cfg_erase
  );
endinterface

// ==== hdl/boot_map_host.sv ====
// Controller end: holds the configuration words and issues requests.
// Assumes a plain register port whose read data stand one cycle later.
`include "boot_map_defs.svh"
module boot_map_host (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  boot_map_if.host         lnk,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata
);
  // -----------------------------------------------------------
  // Registers
  // -----------------------------------------------------------
  logic [31:0] boot_r;
  logic [31:0] flash_r;
  logic [7:0]  cmd_r;
  logic [31:0] target_r;
  logic [31:0] data_r;
  logic [31:0] access_r;
  logic [31:0] result_r;
  logic [31:0] phys_r;
  logic        fail_r;
  logic [1:0]  region_r;
  logic        go_r;
  logic        chip_r;
  logic        dbg_r;
  logic        core_r;
  boot_map_pkg::isp_state_t state_r;
  boot_map_pkg::isp_state_t state_nxt;

  wire wr_boot  = wr & (addr == `BM_REG_BOOT);
  wire wr_flash = wr & (addr == `BM_REG_FLASH);
  wire wr_trg   = wr & (addr == `BM_REG_TRIGGER);
  wire busy     = state_r != boot_map_pkg::st_idle;
  // A command written while one is running is dropped, not queued.
  wire go_take  = wr_trg & wdata[`BM_TRG_GO] & !busy;

  // Erase from the device outranks a software write in the same cycle.
  // The words act as nonvolatile cells, so sys_rst leaves them alone; otherwise a reboot would drop the lock.
  // Their contents are undefined until the first write or erase.
  always_ff @(posedge ref_clk) begin
    if (lnk.cfg_erase) begin
      boot_r  <= `BM_BOOT_ERASED;
      flash_r <= `BM_FLASH_ERASED;
    end else begin
      if (wr_boot) begin
        boot_r <= wdata;
      end
      if (wr_flash) begin
        flash_r <= wdata & `BM_FLASH_MASK;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_r    <= 8'h00;
      target_r <= 32'h0000_0000;
      data_r   <= 32'h0000_0000;
      access_r <= 32'h0000_0000;
    end else if (wr) begin
      if (addr == `BM_REG_CMD) cmd_r <= wdata[7:0];
      if (addr == `BM_REG_TARGET) target_r <= wdata;
      if (addr == `BM_REG_DATA) data_r <= wdata;
      if (addr == `BM_REG_ACCESS) access_r <= wdata;
    end
  end

  // -----------------------------------------------------------
  // Request pulses and command sequencing
  // -----------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      boot_map_pkg::st_idle: if (go_take) state_nxt = boot_map_pkg::st_busy;
      boot_map_pkg::st_busy: if (lnk.isp_done) state_nxt = boot_map_pkg::st_done;
      boot_map_pkg::st_done: state_nxt = boot_map_pkg::st_idle;
      default: state_nxt = boot_map_pkg::st_idle;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= boot_map_pkg::st_idle;
      go_r    <= 1'b0;
      chip_r  <= 1'b0;
      dbg_r   <= 1'b0;
      core_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      go_r    <= go_take;
      chip_r  <= wr_trg & wdata[`BM_TRG_CHIP];
      dbg_r   <= wr_trg & wdata[`BM_TRG_DBG];
      core_r  <= wr_trg & wdata[`BM_TRG_CORE];
    end
  end

  // -----------------------------------------------------------
  // Answer capture
  // -----------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      result_r <= 32'h0000_0000;
      phys_r   <= 32'h0000_0000;
      fail_r   <= 1'b0;
      region_r <= 2'b00;
    end else begin
      if (lnk.isp_done) begin
        result_r <= lnk.isp_rdata;
        fail_r   <= lnk.isp_fail;
      end else if (lnk.dbg_ack) begin
        result_r <= lnk.dbg_rdata;
      end
      if (lnk.core_ack) begin
        phys_r   <= lnk.core_phys;
        region_r <= lnk.core_region;
      end
    end
  end

  // -----------------------------------------------------------
  // Link drive and register read port
  // -----------------------------------------------------------
  assign lnk.boot_word  = boot_r;
  assign lnk.flash_word = flash_r;
  assign lnk.isp_go     = go_r;
  assign lnk.isp_cmd    = cmd_r;
  assign lnk.isp_addr   = target_r;
  assign lnk.raw_data   = data_r;
  assign lnk.chip_erase = chip_r;
  assign lnk.dbg_req    = dbg_r;
  assign lnk.dbg_addr   = access_r;
  assign lnk.core_req   = core_r;
  assign lnk.core_addr  = access_r;

  wire [31:0] status_w = {lnk.vec_page[31:`BM_PAGE_BITS], 5'h00, region_r, fail_r, busy};
  logic [31:0] rd_mux;
  always_comb begin
    case (addr)
      `BM_REG_BOOT:    rd_mux = boot_r;
      `BM_REG_FLASH:   rd_mux = flash_r;
      `BM_REG_CMD:     rd_mux = {24'h000000, cmd_r};
      `BM_REG_TARGET:  rd_mux = target_r;
      `BM_REG_DATA:    rd_mux = data_r;
      `BM_REG_ACCESS:  rd_mux = access_r;
      `BM_REG_STATUS:  rd_mux = status_w;
      `BM_REG_RESULT:  rd_mux = result_r;
      `BM_REG_PHYS:    rd_mux = phys_r;
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= rd ? rd_mux : 32'h0000_0000;
    end
  end
endmodule // boot_map_host

// ==== testbench/boot_map_sva.sv ====
// Concurrent checks on the link between the boot map decoder and its controller.
// Assumes one clock domain and that the bench instantiates it beside the interface.
module boot_map_sva (
  input logic                  ref_clk,
  input logic                  sys_rst,
  input logic [31:0]           boot_word,
  input logic                  core_req,
  input logic [31:0]           core_addr,
  input logic                  core_ack,
  input boot_map_pkg::region_t core_region,
  input logic [31:0]           core_phys,
  input logic                  dbg_req,
  input logic [31:0]           dbg_addr,
  input logic [31:0]           dbg_rdata,
  input logic                  dbg_ack,
  input logic [31:0]           raw_data,
  input logic                  isp_go,
  input logic [7:0]            isp_cmd,
  input logic [31:0]           isp_addr,
  input logic                  isp_done,
  input logic                  isp_fail,
  input logic [31:0]           isp_rdata,
  input logic [31:0]           vec_page,
  input logic                  chip_erase,
  input logic                  cfg_erase
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------
  // Properties
  // ---------------------------------------------------------
  // The live boot word matches the sampled one because the bench never sends requests between a write and reboot.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_go(logic [7:0] c);
    isp_go && isp_cmd == c;
  endsequence
  sequence s_remap_ok;
    s_go(8'h2e) ##1 isp_done && !isp_fail;
  endsequence
  chk_isp_read: assert property (s_go(8'h00) |=> isp_done && isp_rdata == $past(raw_data))
    else $error("isp read data wrong");
  chk_remap_page: assert property (s_remap_ok |-> vec_page == $past(isp_addr))
    else $error("mirrored page not reported");
  chk_remap_align: assert property (isp_go && isp_cmd == 8'h2e && isp_addr[8:0] != 9'h0 |=> isp_done && isp_fail)
    else $error("misaligned remap accepted");
  chk_remap_other: assert property (isp_go && isp_cmd != 8'h2e |=> isp_done && $stable(vec_page))
    else $error("mirror moved without remap");
  chk_erase_cfg: assert property (s_go(8'h22) ##0 isp_addr == 32'h0030_0000 |=> isp_done && cfg_erase)
    else $error("config erase not signalled");
  chk_chip_erase: assert property (chip_erase |=> cfg_erase)
    else $error("chip erase not signalled");
  chk_dbg_lock: assert property (dbg_req && !boot_word[1] &&
    !(dbg_addr inside {32'h0040_0000, 32'h0030_0000, 32'h0030_0004}) |=> dbg_ack && dbg_rdata == 32'hffff_ffff)
    else $error("locked debug read leaked");
  chk_dbg_open: assert property (dbg_req && boot_word[1] |=> dbg_ack && dbg_rdata == $past(raw_data))
    else $error("unlocked debug read wrong");
  chk_core_block: assert property (core_req &&
    ((boot_word[7:6] == 2'b11 && core_addr[31:12] == 20'h00100) ||
     (boot_word[7:6] == 2'b01 && core_addr >= 32'h1000)) |=> core_ack && core_region == boot_map_pkg::rgn_none)
    else $error("blocked region readable");
  chk_core_mirror: assert property (core_req && !boot_word[6] && core_addr < 32'h200 |=>
    core_ack && core_phys == ($past(vec_page) | $past(core_addr)))
    else $error("page zero mirror wrong");
endmodule // boot_map_sva

// ==== testbench/boot_map_and_flash_lock_test.sv ====
// Self-checking bench joining both ends of the boot map link.
// Assumes the controller keeps its configuration words across sys_rst.
module boot_map_and_flash_lock_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] APP = 32'h0002_0000;
  logic        ref_clk, sys_rst, wr, rd, lk, df, f;
  logic [7:0]  addr;
  logic [1:0]  m;
  logic [31:0] wdata, rdata, df_base, vec, raw, base, a, d;
  logic        boot_from_loader, iap_active, lock_active, df_enable, cfg_fault, cfg_loaded;
  int          failures = 0;
  int          checks = 0;
  int          cyc = 0;
  boot_map_if lnk ();
  boot_map_dev #(.APP_SIZE(APP)) i_boot_map_dev (.ref_clk(ref_clk), .sys_rst(sys_rst), .lnk(lnk),
    .boot_from_loader(boot_from_loader), .iap_active(iap_active), .lock_active(lock_active),
    .df_enable(df_enable), .df_base(df_base), .cfg_fault(cfg_fault), .cfg_loaded(cfg_loaded));
  boot_map_host i_boot_map_host (.ref_clk(ref_clk), .sys_rst(sys_rst), .lnk(lnk), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata));
  boot_map_sva i_boot_map_sva (.ref_clk(ref_clk), .sys_rst(sys_rst), .boot_word(lnk.boot_word),
    .core_req(lnk.core_req), .core_addr(lnk.core_addr), .core_ack(lnk.core_ack), .core_region(lnk.core_region),
    .core_phys(lnk.core_phys), .dbg_req(lnk.dbg_req), .dbg_addr(lnk.dbg_addr), .dbg_rdata(lnk.dbg_rdata),
    .dbg_ack(lnk.dbg_ack), .raw_data(lnk.raw_data), .isp_go(lnk.isp_go), .isp_cmd(lnk.isp_cmd),
    .isp_addr(lnk.isp_addr), .isp_done(lnk.isp_done), .isp_fail(lnk.isp_fail), .isp_rdata(lnk.isp_rdata),
    .vec_page(lnk.vec_page), .chip_erase(lnk.chip_erase), .cfg_erase(lnk.cfg_erase));
  // ---------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // The ceiling is more than ten times the expected run, so only a hang reaches it.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wreg(input logic [7:0] ad, input logic [31:0] v);
    @(posedge ref_clk) begin addr <= ad; wdata <= v; wr <= 1'b1; end
    @(posedge ref_clk) wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] ad, output logic [31:0] v);
    @(posedge ref_clk) begin addr <= ad; rd <= 1'b1; end
    @(posedge ref_clk) rd <= 1'b0;
    @(negedge ref_clk) v = rdata;
  endtask
  task automatic rst();
    @(posedge ref_clk) sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  function automatic logic [33:0] emap(input logic [31:0] v, input logic [31:0] ad);
    logic [1:0]  r;
    logic [31:0] p;
    r = 2'b00;
    p = 32'h0;
    if (m == 2'b11 && ad < APP) begin r = 2'b01; p = ad; end
    else if (m == 2'b01 && ad < 32'h1000) begin r = 2'b11; p = 32'h0010_0000 | ad; end
    else if (!m[0] && ad < 32'h200) begin p = v | ad; r = (v[31:12] == 20'h00100) ? 2'b11 : 2'b01; end
    else if (!m[0] && ad < APP) begin r = 2'b01; p = ad; end
    else if (!m[0] && ad[31:12] == 20'h00100) begin r = 2'b11; p = ad; end
    if (r == 2'b01 && !df && p >= base) r = 2'b10;
    return {r, p};
  endfunction
  task automatic core(input logic [31:0] ad);
    logic [33:0] e;
    e = emap(vec, ad);
    wreg(8'h14, ad);
    wreg(8'h18, 32'h8);
    repeat (3) @(posedge ref_clk);
    rreg(8'h1c, d);
    chk("core_region", d[3:2], e[33:32]);
    rreg(8'h24, d);
    chk("core_phys", d, e[31:0]);
  endtask
  task automatic in_system_program(input logic [7:0] c, input logic [31:0] ad);
    wreg(8'h08, {24'h0, c});
    wreg(8'h0c, ad);
    wreg(8'h18, 32'h1);
    repeat (4) @(posedge ref_clk);
    rreg(8'h1c, d);
    f = d[1];
  endtask
  task automatic dbg(input logic [31:0] ad);
    wreg(8'h14, ad);
    wreg(8'h18, 32'h4);
    repeat (3) @(posedge ref_clk);
    rreg(8'h20, d);
    chk("dbg_data", d, (!lk && !(ad inside {32'h0040_0000, 32'h0030_0000, 32'h0030_0004})) ? '1 : raw);
  endtask
  // ---------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h0;
    wdata = 32'h0;
    void'($urandom(32'hb867f901));
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      m = 2'(i);
      lk = 1'(i >> 2);
      df = 1'($urandom);
      base = {15'h0, 8'($urandom), 9'h0};
      wreg(8'h00, {24'hff_ffff, m, 4'hf, lk, df});
      wreg(8'h04, base | 32'hfff0_0001);
      rst();
      vec = (m == 2'b00) ? 32'h0010_0000 : 32'h0;
      rreg(8'h04, d);
      chk("flash_word", d, base);
      chk("from_loader", boot_from_loader, !m[1]);
      chk("iap", iap_active, !m[0]);
      chk("lock", lock_active, !lk);
      chk("df_en", df_enable, !df);
      chk("df_base", df_base, base);
      chk("cfg_fault", cfg_fault, 1'b0);
      chk("loaded", cfg_loaded, 1'b1);
      rreg(8'h1c, d);
      chk("vec_reset", {d[31:9], 9'h0}, vec);
      core($urandom_range(511, 0));
      core(32'h0010_0000 + $urandom_range(4095, 0));
      core($urandom_range(APP - 1, 512));
      core($urandom_range(4095, 0));
      core(APP);
      raw = $urandom;
      wreg(8'h10, raw);
      dbg($urandom);
      dbg(32'h0030_0004);
      dbg(32'h0040_0000);
      in_system_program(8'h00, $urandom);
      rreg(8'h20, d);
      chk("isp_read", d, raw);
      a = {15'h0, 8'($urandom_range(255, 1)), 9'h0};
      for (int j = 0; j < 2; j++) begin
        in_system_program(8'h2e, j ? a : 32'h0010_0000);
        chk("remap_fail", f, m[0]);
        if (!m[0]) vec = j ? a : 32'h0010_0000;
        rreg(8'h1c, d);
        chk("vec_page", {d[31:9], 9'h0}, vec);
        core($urandom_range(511, 0));
      end
      in_system_program(8'h2e, a | 32'h4);
      chk("remap_misalign", f, 1'b1);
      in_system_program(8'h33, 32'h0);
      chk("bad_cmd", f, 1'b1);
    end
    in_system_program(8'h04, 32'h0);
    rreg(8'h20, d);
    chk("isp_read_id", d, raw);
    in_system_program(8'h21, 32'h0);
    chk("program_ok", f, 1'b0);
    in_system_program(8'h22, 32'h4);
    chk("erase_misalign", f, 1'b1);
    rreg(8'h40, d);
    chk("unmapped", d, 32'h0);
    wreg(8'h00, 32'hffff_fffd);
    rst();
    in_system_program(8'h22, 32'h0030_0000);
    chk("erase_fail", f, 1'b0);
    rreg(8'h00, d);
    chk("erased_word", d, 32'hffff_ffff);
    chk("lock_held", lock_active, 1'b1);
    rst();
    chk("lock_free", lock_active, 1'b0);
    wreg(8'h00, 32'hffff_fffd);
    rst();
    wreg(8'h18, 32'h2);
    repeat (3) @(posedge ref_clk);
    rreg(8'h04, d);
    chk("chip_erase", d, 32'h000f_fe00);
    rst();
    chk("lock_chip", lock_active, 1'b0);
    conclude();
  end
endmodule // boot_map_and_flash_lock_test
